// ===== inc/adc_cal_trim_defines.svh
// Offsets, field positions, reset values and timing counts of the calibration and trim block
`ifndef ADC_CAL_TRIM_DEFINES_SVH
`define ADC_CAL_TRIM_DEFINES_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define REG_CTRL 8'h00
`define REG_SOFT_TRIG 8'h04
`define REG_STATUS 8'h08
`define REG_IRQ_STATUS 8'h0c
`define REG_IRQ_MASK 8'h10
`define REG_TRIM_BASE 8'h20
`define TRIM_COUNT 26

// ----------------------------------------
// Control fields
// ----------------------------------------
`define CTRL_CAL_EN 0
`define CTRL_FG_OFS 1
`define CTRL_BG_OFS 2
`define CTRL_BG_CAL 3
`define CTRL_TRIG_SEL 4
`define CTRL_SINGLE 5
`define CTRL_IN_SEL 6
`define CTRL_WIDTH 7

// ----------------------------------------
// Interrupt status bits
// ----------------------------------------
`define IRQ_FOREGROUND_CAL_COMPLETE 0
`define IRQ_REFUSED 1
`define IRQ_BG_OFS 2
`define IRQ_WIDTH 3

// ----------------------------------------
// Trim word indexes
// ----------------------------------------
`define T_A0_VINA 5'd0
`define T_A0_VINB 5'd1
`define T_A90_VINA 5'd2
`define T_A90_VINB 5'd3
`define T_B0_VINA 5'd4
`define T_B0_VINB 5'd5
`define T_GAIN_DUAL 5'd6
`define T_GAIN_SINGLE 5'd10
`define T_FS_A 5'd14
`define T_FS_B 5'd15
`define T_TIME_P0 5'd16
`define T_TIME_P90 5'd20
`define T_SKEW_A 5'd24
`define T_SKEW_B 5'd25

// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define TRIM_RESET 16'h8000
`define FS_RESET 16'ha000
`define CLK_PERIOD_NS 20
`define FG_CORE_TIME_NS 2560
`define FG_OFS_TIME_NS 1280
`define BG_OFS_PERIOD_NS 10240
`define FG_CORE_CYCLES (`FG_CORE_TIME_NS / `CLK_PERIOD_NS)
`define FG_OFS_CYCLES (`FG_OFS_TIME_NS / `CLK_PERIOD_NS)
`define BG_OFS_CYCLES (`BG_OFS_PERIOD_NS / `CLK_PERIOD_NS)

`endif

// ===== inc/adc_cal_trim_pkg.sv
// Types of the calibration and trim block
package adc_cal_trim_pkg;

	typedef enum logic [1:0]
	{
		S_IDLE = 2'b00,
		S_FG_CORE = 2'b01,
		S_FG_OFS = 2'b10
	} cal_state_type;

	typedef struct packed
	{
		logic [15:0] offset_a;
		logic [15:0] offset_b;
		logic [3:0][15:0] gain;
		logic [3:0][15:0] timing;
		logic [15:0] skew_a;
		logic [15:0] skew_b;
		logic [15:0] fs_a;
		logic [15:0] fs_b;
	} applied_trim_type;

endpackage

// ===== src/adc_cal_trim.sv
// Offset calibration sequencer and trim selection with a Wishbone register port
`timescale 1ns/10ps
`include "adc_cal_trim_defines.svh"

module adc_cal_trim
	import adc_cal_trim_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	output logic irq_o,
	input wire logic calibration_trigger_pin_i,
	input wire logic [15:0] offset_meas_a_i,
	input wire logic [15:0] offset_meas_b_i,
	input wire logic [11:0] sample_i,
	output logic [11:0] sample_o,
	output logic cores_offline_o,
	output applied_trim_type trim_o
);

	// ----------------------------------------
	// Address decoding
	// ----------------------------------------
	function automatic logic is_trim(input logic [7:0] adr);
		is_trim = (adr >= `REG_TRIM_BASE) && (adr < (`REG_TRIM_BASE + 8'(4 * `TRIM_COUNT))) && (adr[1:0] == 2'b00);
	endfunction

	function automatic logic [4:0] trim_index(input logic [7:0] adr);
		logic [7:0] rel;
		rel = adr - `REG_TRIM_BASE;
		trim_index = rel[6:2];
	endfunction

	logic [`CTRL_WIDTH-1:0] ctrl;
	logic [`IRQ_WIDTH-1:0] irq_status;
	logic [`IRQ_WIDTH-1:0] irq_mask;
	logic [15:0] trim_mem [0:`TRIM_COUNT-1];
	cal_state_type state;
	logic [11:0] count;
	logic [11:0] bg_count;
	logic foreground_cal_complete;
	logic pin_prev;
	logic ack;

	logic req;
	logic bus_wr;
	logic bus_rd;
	logic fg_offset_cal_enable;
	logic bg_offset_cal_enable;
	logic bg_cal_enable;
	logic trigger_source_select;
	logic single_mode;
	logic in_sel;
	logic cal_en_rise;
	logic software_calibration_trigger;
	logic pin_rise;
	logic fg_start;
	logic fg_end;
	logic ofs_write;
	logic bg_ofs_step;
	logic trim_wr_ok;
	logic trim_refused;
	logic [`IRQ_WIDTH-1:0] irq_event;
	logic [15:0] next_gain [0:3];
	logic [15:0] next_timing [0:3];

	assign req = cyc_i && stb_i && !ack;
	// Writes commit at the edge at which the master samples ack high
	assign bus_wr = cyc_i && stb_i && we_i && ack;
	assign bus_rd = req && !we_i;
	assign fg_offset_cal_enable = ctrl[`CTRL_FG_OFS];
	assign bg_offset_cal_enable = ctrl[`CTRL_BG_OFS];
	assign bg_cal_enable = ctrl[`CTRL_BG_CAL];
	assign trigger_source_select = ctrl[`CTRL_TRIG_SEL];
	assign single_mode = ctrl[`CTRL_SINGLE];
	assign in_sel = ctrl[`CTRL_IN_SEL];

	// ----------------------------------------
	// Calibration triggers
	// ----------------------------------------
	assign cal_en_rise = bus_wr && (adr_i == `REG_CTRL) && sel_i[0] && dat_i[`CTRL_CAL_EN] && !ctrl[`CTRL_CAL_EN];
	assign software_calibration_trigger = bus_wr && (adr_i == `REG_SOFT_TRIG) && sel_i[0] && dat_i[0];
	assign pin_rise = calibration_trigger_pin_i && !pin_prev;
	assign fg_start = (state == S_IDLE) && !bg_cal_enable && (cal_en_rise || (trigger_source_select ? pin_rise : software_calibration_trigger));
	assign fg_end = ((state == S_FG_CORE) && (count == 12'(`FG_CORE_CYCLES - 1)) && !fg_offset_cal_enable)
		|| ((state == S_FG_OFS) && (count == 12'(`FG_OFS_CYCLES - 1)));
	assign ofs_write = (state == S_FG_OFS) && (count == 12'(`FG_OFS_CYCLES - 1));
	assign bg_ofs_step = bg_cal_enable && bg_offset_cal_enable && (state == S_IDLE) && (bg_count == 12'(`BG_OFS_CYCLES - 1));

	// Trim writes are refused during background calibration and, for offset trims, in offset modes
	assign trim_wr_ok = !bg_cal_enable && !((trim_index(adr_i) <= `T_B0_VINB) && (fg_offset_cal_enable || bg_offset_cal_enable));
	assign trim_refused = bus_wr && is_trim(adr_i) && !trim_wr_ok;
	assign irq_event = {bg_ofs_step, trim_refused, fg_end};

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			pin_prev <= 1'b0;
		else
			pin_prev <= calibration_trigger_pin_i;
	end

	// ----------------------------------------
	// Foreground sequencer
	// ----------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			state <= S_FG_CORE;
			count <= 12'h000;
		end
		else
		begin
			case (state)
				S_IDLE:
				begin
					count <= 12'h000;
					if (fg_start)
						state <= S_FG_CORE;
				end
				S_FG_CORE:
				begin
					count <= count + 12'h001;
					if (count == 12'(`FG_CORE_CYCLES - 1))
					begin
						count <= 12'h000;
						state <= fg_offset_cal_enable ? S_FG_OFS : S_IDLE;
					end
				end
				S_FG_OFS:
				begin
					count <= count + 12'h001;
					if (count == 12'(`FG_OFS_CYCLES - 1))
					begin
						count <= 12'h000;
						state <= S_IDLE;
					end
				end
				default:
					state <= S_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			bg_count <= 12'h000;
		else if (!(bg_cal_enable && bg_offset_cal_enable) || bg_ofs_step)
			bg_count <= 12'h000;
		else if (state == S_IDLE)
			bg_count <= bg_count + 12'h001;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			foreground_cal_complete <= 1'b0;
		else if (fg_start)
			foreground_cal_complete <= 1'b0;
		else if (fg_end)
			foreground_cal_complete <= 1'b1;
	end

	// ----------------------------------------
	// Control and interrupt registers
	// ----------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			ctrl <= '0;
		else if (bus_wr && (adr_i == `REG_CTRL) && sel_i[0])
			ctrl <= dat_i[`CTRL_WIDTH-1:0];
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			irq_mask <= '0;
		else if (bus_wr && (adr_i == `REG_IRQ_MASK) && sel_i[0])
			irq_mask <= dat_i[`IRQ_WIDTH-1:0];
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			irq_status <= '0;
		else if (bus_rd && (adr_i == `REG_IRQ_STATUS))
			irq_status <= irq_event;
		else
			irq_status <= irq_status | irq_event;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			irq_o <= 1'b0;
		else
			irq_o <= |(irq_status & irq_mask);
	end

	// ----------------------------------------
	// Trim storage
	// ----------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			for (int i = 0; i < `TRIM_COUNT; i++)
				trim_mem[i] <= `TRIM_RESET;
			trim_mem[`T_FS_A] <= `FS_RESET;
			trim_mem[`T_FS_B] <= `FS_RESET;
		end
		else if (ofs_write || bg_ofs_step)
		begin
			if (single_mode)
			begin
				trim_mem[in_sel ? `T_A90_VINB : `T_A90_VINA] <= offset_meas_a_i;
				trim_mem[in_sel ? `T_B0_VINB : `T_B0_VINA] <= offset_meas_b_i;
			end
			else
			begin
				trim_mem[`T_A0_VINA] <= offset_meas_a_i;
				trim_mem[`T_B0_VINB] <= offset_meas_b_i;
			end
		end
		else if (bus_wr && is_trim(adr_i) && trim_wr_ok)
		begin
			if (sel_i[0])
				trim_mem[trim_index(adr_i)][7:0] <= dat_i[7:0];
			if (sel_i[1])
				trim_mem[trim_index(adr_i)][15:8] <= dat_i[15:8];
		end
	end

	// ----------------------------------------
	// Applied trims by channel mode
	// ----------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			trim_o <= '0;
		else
		begin
			if (single_mode)
			begin
				trim_o.offset_a <= trim_mem[in_sel ? `T_A90_VINB : `T_A90_VINA];
				trim_o.offset_b <= trim_mem[in_sel ? `T_B0_VINB : `T_B0_VINA];
			end
			else
			begin
				trim_o.offset_a <= trim_mem[`T_A0_VINA];
				trim_o.offset_b <= trim_mem[`T_B0_VINB];
			end
			trim_o.skew_a <= trim_mem[`T_SKEW_A];
			trim_o.skew_b <= trim_mem[`T_SKEW_B];
			trim_o.fs_a <= trim_mem[`T_FS_A];
			trim_o.fs_b <= trim_mem[`T_FS_B];
			// Gain of every bank and timing of banks 0 and 1 follow the channel mode
			for (int b = 0; b < 4; b++)
			begin
				trim_o.gain[b] <= next_gain[b];
				trim_o.timing[b] <= next_timing[b];
			end
		end
	end

	// ----------------------------------------
	// Bank trim selection
	// ----------------------------------------
	// Banks 0 to 3 of the carrier are core A bank 0, 1 and core B bank 0, 1
	for (genvar b = 0; b < 4; b++)
	begin : g_bank
		assign next_gain[b] = single_mode ? trim_mem[`T_GAIN_SINGLE + 5'(b)] : trim_mem[`T_GAIN_DUAL + 5'(b)];
		assign next_timing[b] = (single_mode && (b < 2)) ? trim_mem[`T_TIME_P90 + 5'(b)]
			: trim_mem[`T_TIME_P0 + 5'(b)];
	end

	// ----------------------------------------
	// Sample path
	// ----------------------------------------
	// Mid code while a foreground calibration runs
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			cores_offline_o <= 1'b1;
			sample_o <= 12'h000;
		end
		else
		begin
			cores_offline_o <= (state != S_IDLE) || fg_start;
			sample_o <= ((state != S_IDLE) || fg_start) ? 12'h000 : sample_i;
		end
	end

	// ----------------------------------------
	// Wishbone answer
	// ----------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			ack <= 1'b0;
		else
			ack <= req;
	end

	assign ack_o = ack;

	// Read data is registered and stands with ack for one cycle
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			dat_o <= 32'h0000_0000;
		else if (bus_rd)
		begin
			if (adr_i == `REG_CTRL)
				dat_o <= 32'(ctrl);
			else if (adr_i == `REG_STATUS)
				dat_o <= {28'h0000000, single_mode, bg_cal_enable && bg_offset_cal_enable,
					state != S_IDLE, foreground_cal_complete};
			else if (adr_i == `REG_IRQ_STATUS)
				dat_o <= 32'(irq_status);
			else if (adr_i == `REG_IRQ_MASK)
				dat_o <= 32'(irq_mask);
			else if (is_trim(adr_i))
				dat_o <= {16'h0000, trim_mem[trim_index(adr_i)]};
			else
				dat_o <= 32'h0000_0000;
		end
	end

endmodule

// ===== test/adc_cal_trim_host.sv
// Wishbone host model standing in for register software
`timescale 1ns/10ps
module adc_cal_trim_host
(
	input wire logic clk_i,
	input wire logic ack_i,
	input wire logic [31:0] dat_i,
	output logic cyc_o,
	output logic stb_o,
	output logic we_o,
	output logic [7:0] adr_o,
	output logic [3:0] sel_o,
	output logic [31:0] dat_o
);
	initial
	begin
		{cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} = '0;
	end
	// Request held until ack is sampled, then released for at least one cycle
	task xfer(input logic w, input logic [7:0] a, input logic [15:0] wd, output logic [15:0] rd);
		@(posedge clk_i);
		{cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} <= {2'b11, w, a, 4'h3, 16'h0000, wd};
		do @(posedge clk_i); while (ack_i !== 1'b1);
		rd = dat_i[15:0];
		{cyc_o, stb_o, we_o} <= 3'b000;
	endtask
endmodule

// ===== test/adc_cal_trim_sva.sv
// Checker of bus answers, offline output and trim update timing
`timescale 1ns/10ps
module adc_cal_trim_sva
	import adc_cal_trim_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	input wire logic [31:0] dat_o,
	input wire logic ack_o,
	input wire logic irq_o,
	input wire logic calibration_trigger_pin_i,
	input wire logic [15:0] offset_meas_a_i,
	input wire logic [15:0] offset_meas_b_i,
	input wire logic [11:0] sample_i,
	input wire logic [11:0] sample_o,
	input wire logic cores_offline_o,
	input wire applied_trim_type trim_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic [8:0] run_len;
	always_ff @(posedge clk_i)
	begin
		if (rst_i || !cores_offline_o)
		begin
			run_len <= 9'h000;
		end
		else
		begin
			run_len <= run_len + 9'h001;
		end
	end
	a_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("no ack one cycle after request");
	a_ack_single: assert property (ack_o |=> !ack_o) else $error("ack longer than one cycle");
	a_offline_output: assert property (cores_offline_o |-> sample_o == 12'h000)
		else $error("sample not mid code while offline");
	a_online_pass: assert property (!cores_offline_o && !$past(cores_offline_o) |-> sample_o == $past(sample_i))
		else $error("sample not passed while online");
	a_offline_length: assert property ($fell(cores_offline_o) |-> run_len inside {[9'd126:9'd130], [9'd190:9'd194]})
		else $error("calibration run of wrong length");
	a_gain_by_bus: assert property ($changed(trim_o.gain) |-> ack_o || $past(ack_o) || $past(ack_o, 2) || $past(rst_i, 2))
		else $error("gain trim changed without bus access");
	a_timing_by_bus: assert property (!ack_o && !$past(ack_o) && !$past(ack_o, 2) && !$past(rst_i, 2) |-> $stable(trim_o.timing))
		else $error("timing trim changed without bus access");
	a_skew_by_bus: assert property ($changed({trim_o.skew_a, trim_o.skew_b}) |-> $past(ack_o, 1) || $past(ack_o, 2) || ack_o || $past(rst_i, 2))
		else $error("skew trim changed without bus access");
	c_offset_run: cover property ($fell(cores_offline_o) && run_len > 9'd150);
	c_irq_raised: cover property ($rose(irq_o));
	c_bus_write: cover property (cyc_i && stb_i && we_i && ack_o);
endmodule

bind adc_cal_trim adc_cal_trim_sva u_sva (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
	.adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .irq_o(irq_o),
	.calibration_trigger_pin_i(calibration_trigger_pin_i), .offset_meas_a_i(offset_meas_a_i),
	.offset_meas_b_i(offset_meas_b_i), .sample_i(sample_i), .sample_o(sample_o),
	.cores_offline_o(cores_offline_o), .trim_o(trim_o));

// ===== test/tb_adc_cal_trim.sv
// Self-checking bench of the calibration and trim block
`timescale 1ns/10ps
module tb_adc_cal_trim
	import adc_cal_trim_pkg::*;
();
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic pin = 1'b0;
	logic [15:0] ma = 16'h0000;
	logic [15:0] mb = 16'h0000;
	logic [11:0] smp = 12'h000;
	logic cyc, stb, we, ack, irq, offl;
	logic [7:0] adr;
	logic [3:0] sel;
	logic [31:0] wdat, rdat;
	logic [11:0] so;
	applied_trim_type trim;
	logic [15:0] m [26];
	logic [15:0] rnd = 16'h0025;
	logic [15:0] d;
	int fail_count = 0;
	int checks_done = 0;
	int cycles = 0;
	always #10 clk_i = ~clk_i;
	adc_cal_trim dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
		.dat_i(wdat), .dat_o(rdat), .ack_o(ack), .irq_o(irq), .calibration_trigger_pin_i(pin),
		.offset_meas_a_i(ma), .offset_meas_b_i(mb), .sample_i(smp), .sample_o(so), .cores_offline_o(offl),
		.trim_o(trim));
	adc_cal_trim_host host (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .stb_o(stb), .we_o(we),
		.adr_o(adr), .sel_o(sel), .dat_o(wdat));
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task end_of_test();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	always @(posedge clk_i)
	begin
		cycles <= cycles + 1;
		smp <= smp + 12'h3a5;
		if (cycles == 20000)
		begin
			fail_count++;
			end_of_test();
		end
	end
	task chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", n, exp, seen);
		end
	endtask
	task wr(input logic [7:0] a, input logic [15:0] v);
		host.xfer(1'b1, a, v, d);
	endtask
	task rd(input logic [7:0] a);
		host.xfer(1'b0, a, 16'h0000, d);
	endtask
	task wait_done();
		do rd(8'h08); while (d[0] !== 1'b1);
	endtask
	task chk_map(input int s, input int ins);
		repeat (3) @(posedge clk_i);
		chk("offset_a", trim.offset_a, s ? m[2 + ins] : m[0]);
		chk("offset_b", trim.offset_b, s ? m[4 + ins] : m[5]);
		for (int i = 0; i < 4; i++)
		begin
			chk("gain", trim.gain[i], m[(s ? 10 : 6) + i]);
			chk("timing", trim.timing[i], m[(s && i < 2 ? 20 : 16) + i]);
		end
		chk("skew_a", trim.skew_a, m[24]);
		chk("skew_b", trim.skew_b, m[25]);
		chk("fs_a", trim.fs_a, m[14]);
		chk("fs_b", trim.fs_b, m[15]);
		chk("sample", {4'h0, so}, {4'h0, smp - 12'h3a5});
	endtask
	initial
	begin
		for (int i = 0; i < 26; i++)
			m[i] = (i == 14 || i == 15) ? 16'ha000 : 16'h8000;
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		wait_done();
		rd(8'h0c);
		chk("irq_done", d & 16'h0001, 16'h0001);
		rd(8'h0c);
		chk("irq_clear", d, 16'h0000);
		rd(8'h1c);
		chk("unmapped", d, 16'h0000);
		wr(8'h00, 16'h0000);
		for (int i = 0; i < 26; i++)
		begin
			rd(8'h20 + 8'(4 * i));
			chk("trim_reset", d, m[i]);
			rnd = lfsr(rnd);
			if (i != 14 && i != 15)
				m[i] = rnd; // Full scale kept at default while gains change
			wr(8'h20 + 8'(4 * i), m[i]);
		end
		for (int i = 0; i < 26; i++)
		begin
			rd(8'h20 + 8'(4 * i));
			chk("trim_rw", d, m[i]);
		end
		chk_map(0, 0);
		for (int s = 0; s < 2; s++)
		begin
			wr(8'h00, 16'h0020 | 16'(s << 6));
			chk_map(1, s);
		end
		wr(8'h00, 16'h0000);
		ma <= lfsr(rnd);
		mb <= rnd;
		wr(8'h00, 16'h0002); // Offset step enabled before start
		wr(8'h00, 16'h0003);
		@(posedge clk_i);
		chk("offline", {15'h0000, offl}, 16'h0001);
		chk("offline_sample", {4'h0, so}, 16'h0000);
		rd(8'h08);
		chk("done_clear", d & 16'h0001, 16'h0000);
		wr(8'h20, 16'h1234); // Refused while offset mode is on
		wait_done(); // Offset trims read only after completion
		m[0] = ma;
		m[5] = mb;
		rd(8'h20);
		chk("ofs_a", d, m[0]);
		rd(8'h34);
		chk("ofs_b", d, m[5]);
		chk_map(0, 0);
		wr(8'h10, 16'h0003);
		repeat (2) @(posedge clk_i);
		chk("irq_high", {15'h0000, irq}, 16'h0001);
		rd(8'h0c);
		chk("irq_bits", d & 16'h0003, 16'h0003);
		repeat (2) @(posedge clk_i);
		chk("irq_low", {15'h0000, irq}, 16'h0000);
		wr(8'h00, 16'h0011);
		pin <= 1'b1;
		repeat (3) @(posedge clk_i);
		chk("pin_start", {15'h0000, offl}, 16'h0001);
		pin <= 1'b0;
		wait_done();
		wr(8'h00, 16'h0001);
		wr(8'h04, 16'h0001);
		@(posedge clk_i);
		chk("soft_start", {15'h0000, offl}, 16'h0001);
		wait_done();
		ma <= ~ma;
		mb <= ~mb;
		wr(8'h00, 16'h000c);
		wr(8'h38, 16'h0bad); // Trim write attempted in background mode
		do rd(8'h0c); while (d[2] !== 1'b1);
		wr(8'h00, 16'h0000); // Background offset stopped before reading trims
		rd(8'h20);
		chk("bg_ofs_a", d, ~m[0]);
		rd(8'h34);
		chk("bg_ofs_b", d, ~m[5]);
		rd(8'h38);
		chk("bg_refused", d, m[6]);
		end_of_test();
	end
endmodule
